// *** hw/srpps_pkg.sv ***
/*
 * Package for the receive pointer and path status block: register offsets,
 * field positions, reset values and persistence counts.
 * Assumes: Avalon-MM 32-bit word slave, byte addresses.
 */
package srpps_pkg;

   // register map (byte addresses, one word each; 8'hDA, 8'hD2 and 8'hD6 are not word aligned)
   localparam logic [7:0] SRPPS_OFF_PATH_CFG   = 8'hA4;
   localparam logic [7:0] SRPPS_OFF_PTR_STATUS = 8'hDA;
   localparam logic [7:0] SRPPS_OFF_EVENT      = 8'hD2;
   localparam logic [7:0] SRPPS_OFF_EVT_ENABLE = 8'hD6;
   localparam logic [7:0] SRPPS_OFF_EVT_CLEAR  = 8'hB0;
   localparam logic [7:0] SRPPS_OFF_SIZE_CFG   = 8'hB4;
   localparam logic [7:0] SRPPS_OFF_PATH_STAT  = 8'hB8;
   localparam logic [7:0] SRPPS_OFF_B3_COUNT   = 8'hBC;
   localparam logic [7:0] SRPPS_OFF_REI_COUNT  = 8'hC0;

   // status word bit positions
   localparam int SRPPS_ST_CONCAT = 5;
   localparam int SRPPS_ST_LOP    = 2;
   localparam int SRPPS_ST_NDF    = 1;
   localparam int SRPPS_ST_AIS    = 0;

   // path configuration fields
   localparam int SRPPS_CF_RDI_CNT_HI = 15;
   localparam int SRPPS_CF_RDI_CNT_LO = 14;
   localparam int SRPPS_CF_RDI_ENH    = 13;
   localparam int SRPPS_CF_SLM_CNT    = 12;
   localparam int SRPPS_CF_SLM_FORCE  = 11;
   localparam int SRPPS_CF_B3_BLOCK   = 10;
   localparam int SRPPS_CF_REI_BLOCK  = 9;
   localparam int SRPPS_CF_STUFF      = 8;
   localparam int SRPPS_CF_RDI_LCD    = 7;
   localparam logic [15:0] SRPPS_CFG_RESET = 16'h6080;

   // size-bit config fields: [0] enable, [4:3] expected
   localparam int SRPPS_SZ_EN     = 0;
   localparam int SRPPS_SZ_EXP_LO = 3;

   // pointer patterns
   localparam logic [3:0]  SRPPS_CONCAT_NDF = 4'h9;
   localparam logic [15:0] SRPPS_ALL_ONES   = 16'hFFFF;
   localparam logic [9:0]  SRPPS_PTR_MAX    = 10'h30A;

   // persistence counts
   localparam logic [4:0] SRPPS_RDI_N3  = 5'h03;
   localparam logic [4:0] SRPPS_RDI_N5  = 5'h05;
   localparam logic [4:0] SRPPS_RDI_N10 = 5'h0A;
   localparam logic [4:0] SRPPS_RDI_N16 = 5'h10;
   localparam logic [2:0] SRPPS_SLM_N3  = 3'h3;
   localparam logic [2:0] SRPPS_SLM_N5  = 3'h5;

   // fixed stuff columns in STS-1 SPE
   localparam logic [6:0] SRPPS_STUFF_COL_A = 7'h1E;
   localparam logic [6:0] SRPPS_STUFF_COL_B = 7'h3B;

   // event field width: 4 bits, not referenced; the event registers are 6 bits
   localparam int SRPPS_EVT_W = 4;

endpackage : srpps_pkg

// *** hw/srpps_persist.sv ***
/*
 * Persistence filter: a value is accepted after N consecutive equal samples.
 * Assumes synchronous sample strobe and a count that is at least one.
 */
`timescale 1ns/10ps
`default_nettype none
module srpps_persist #(
   parameter int W = 3,
   parameter int CW = 5
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rstSyncN,
   // samples
   input  wire logic          sampleValid,
   input  wire logic [W-1:0]  sampleVal,
   input  wire logic [CW-1:0] needCount,
   // filtered value
   output var  logic [W-1:0]  acceptedVal
);
   typedef struct packed {
      logic [W-1:0]  last;
      logic [CW-1:0] run;
      logic [W-1:0]  acc;
   } srpps_pst_t;

   srpps_pst_t stReg;
   srpps_pst_t stNext;

   // run length of identical samples; saturates at the needed count
   always_comb begin
      stNext = stReg;
      if (sampleValid) begin
         if (sampleVal != stReg.last) begin
            stNext.last = sampleVal;
            stNext.run  = CW'(1);
         end else if (stReg.run < needCount) begin
            stNext.run = stReg.run + CW'(1);
         end
         if (((sampleVal == stReg.last) ? stReg.run + CW'(1) : CW'(1)) >= needCount) begin
            stNext.acc = sampleVal;
         end
      end
   end

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         stReg <= '0;
      end else begin
         stReg <= stNext;
      end
   end

   assign acceptedVal = stReg.acc;
endmodule : srpps_persist
`default_nettype wire

// *** hw/srpps_top.sv ***
/*
 * Receive pointer and path status block: per-frame pointer interpretation,
 * path RDI and label filters, parity counters and the register bank.
 * Assumes: frame stream delivers one pointer word per frame on ptrValid,
 * Avalon-MM master with waitrequest, one clock at 125 MHz.
 */
`timescale 1ns/10ps
`default_nettype none
module srpps_top (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // avalon-mm slave
   input  wire logic [7:0]  avsAddress,
   input  wire logic        avsRead,
   input  wire logic        avsWrite,
   input  wire logic [31:0] avsWritedata,
   output var  logic [31:0] avsReaddata,
   output var  logic        avsWaitrequest,
   // received pointer, one word per frame
   input  wire logic        ptrValid,
   input  wire logic [15:0] ptrWord,
   input  wire logic        ptrConcatCheck,
   // received path overhead, one set per frame
   input  wire logic        pohValid,
   input  wire logic [7:0]  pohG1,
   input  wire logic        labelMismatch,
   input  wire logic        label_unstable_status,
   input  wire logic [3:0]  b3BitErrors,
   input  wire logic [3:0]  reiBitErrors,
   // payload column and alarms
   input  wire logic        sts1Mode,
   input  wire logic [6:0]  speColumn,
   input  wire logic        cell_delineation_loss_status,
   // outputs to the path
   output var  logic        payloadColumn,
   output var  logic        rdiPayloadInsert,
   output var  logic [2:0]  path_rdi_status,
   output var  logic        label_mismatch_status,
   output var  logic        irq
);
   import srpps_pkg::*;

   typedef enum logic [1:0] {
      SRPPS_BUS_IDLE = 2'b01,
      SRPPS_BUS_ACK  = 2'b10
   } srpps_bus_t;

   typedef struct packed {
      srpps_bus_t  bus;
      logic [31:0] rdata;
      logic [15:0] rx_path_config_one;
      logic [4:0]  sizeCfg;
      logic [5:0]  rx_pointer_status;
      logic [5:0]  rx_pointer_event_latch;
      logic [5:0]  evtEnable;
      logic [2:0]  slmRun;
      logic        slmSt;
      logic [15:0] b3Count;
      logic [15:0] reiCount;
   } srpps_state_t;

   srpps_state_t sReg;
   srpps_state_t sNext;
   logic         rstSyncN;
   logic [2:0]   rdiSample;
   logic [4:0]   rdiNeed;
   logic [2:0]   rdiAcc;
   logic [5:0]   statusNew;
   logic         ptrInvalid;
   logic         sizeBad;
   logic         concatBad;
   logic         accept;

   // reset release through two flip-flops, kept apart from the state struct
   logic [1:0] rstPipe;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstPipe <= 2'b00;
      end else begin
         rstPipe <= {rstPipe[0], 1'b1};
      end
   end
   assign rstSyncN = rstPipe[1];

   // pointer interpretation
   always_comb begin
      ptrInvalid = (ptrWord[9:0] > SRPPS_PTR_MAX) && (ptrWord != SRPPS_ALL_ONES);
      sizeBad = sReg.sizeCfg[SRPPS_SZ_EN] &&
                (ptrWord[11:10] != sReg.sizeCfg[SRPPS_SZ_EXP_LO+1:SRPPS_SZ_EXP_LO]);
      concatBad = ptrConcatCheck && (ptrWord != SRPPS_ALL_ONES) &&
                  !((ptrWord[15:12] == SRPPS_CONCAT_NDF) && !sizeBad && (ptrWord[9:0] == 10'h3FF));
      statusNew = '0;
      statusNew[SRPPS_ST_CONCAT] = concatBad;
      statusNew[SRPPS_ST_LOP]    = !ptrConcatCheck && (ptrInvalid || sizeBad);
      statusNew[SRPPS_ST_NDF]    = (ptrWord[15:12] == SRPPS_CONCAT_NDF);
      statusNew[SRPPS_ST_AIS]    = (ptrWord == SRPPS_ALL_ONES);
   end

   always_comb begin
      if (sReg.rx_path_config_one[SRPPS_CF_RDI_ENH]) begin
         rdiSample = pohG1[3:1];
      end else begin
         rdiSample = {pohG1[3], 2'b00};
      end
      case (sReg.rx_path_config_one[SRPPS_CF_RDI_CNT_HI:SRPPS_CF_RDI_CNT_LO])
         2'b11:   rdiNeed = SRPPS_RDI_N16;
         2'b10:   rdiNeed = SRPPS_RDI_N10;
         2'b01:   rdiNeed = SRPPS_RDI_N5;
         default: rdiNeed = SRPPS_RDI_N3;
      endcase
   end

   srpps_persist #(.W(3), .CW(5)) uRdi (
      .clk         (clk),
      .rstSyncN    (rstSyncN),
      .sampleValid (pohValid),
      .sampleVal   (rdiSample),
      .needCount   (rdiNeed),
      .acceptedVal (rdiAcc)
   );

   assign accept = avsRead || avsWrite;

   // next state: bus, registers, status, filters, counters
   always_comb begin
      sNext = sReg;
      if (ptrValid) begin
         sNext.rx_pointer_status = statusNew;
      end
      // bus answers one cycle after the request is seen
      case (sReg.bus)
         SRPPS_BUS_IDLE: begin
            if (accept) begin
               sNext.bus = SRPPS_BUS_ACK;
               sNext.rdata = '0;
               if (avsRead) begin
                  case (avsAddress)
                     SRPPS_OFF_PATH_CFG:   sNext.rdata = {16'h0000, sReg.rx_path_config_one};
                     SRPPS_OFF_PTR_STATUS: sNext.rdata = {26'h0, sReg.rx_pointer_status};
                     SRPPS_OFF_EVENT:      sNext.rdata = {26'h0, sReg.rx_pointer_event_latch};
                     SRPPS_OFF_EVT_ENABLE: sNext.rdata = {26'h0, sReg.evtEnable};
                     SRPPS_OFF_SIZE_CFG:   sNext.rdata = {27'h0, sReg.sizeCfg};
                     SRPPS_OFF_PATH_STAT:  sNext.rdata = {28'h0, sReg.slmSt, rdiAcc};
                     SRPPS_OFF_B3_COUNT:   sNext.rdata = {16'h0000, sReg.b3Count};
                     SRPPS_OFF_REI_COUNT:  sNext.rdata = {16'h0000, sReg.reiCount};
                     default:              sNext.rdata = '0;
                  endcase
               end
            end
         end
         SRPPS_BUS_ACK: begin
            sNext.bus = SRPPS_BUS_IDLE;
            if (avsWrite) begin
               case (avsAddress)
                  SRPPS_OFF_PATH_CFG:   sNext.rx_path_config_one = avsWritedata[15:0];
                  SRPPS_OFF_EVT_ENABLE: sNext.evtEnable = avsWritedata[5:0];
                  SRPPS_OFF_SIZE_CFG:   sNext.sizeCfg = avsWritedata[4:0];
                  SRPPS_OFF_EVT_CLEAR:  sNext.rx_pointer_event_latch =
                                           sReg.rx_pointer_event_latch & ~avsWritedata[5:0];
                  default:              ; // unmapped and read-only words ignore writes
               endcase
            end
            // read clears reported bits
            // an event latched during the wait cycle was not in the read data, so it survives
            if (avsRead && avsAddress == SRPPS_OFF_EVENT) begin
               sNext.rx_pointer_event_latch = sReg.rx_pointer_event_latch & ~sReg.rdata[5:0];
            end
         end
         default: sNext.bus = SRPPS_BUS_IDLE;
      endcase
      // changes latch, set wins over clear
      if (ptrValid) begin
         sNext.rx_pointer_event_latch = sNext.rx_pointer_event_latch |
                                        ((statusNew ^ sReg.rx_pointer_status) & 6'h27);
      end
      if (pohValid) begin
         if (labelMismatch) begin
            if (sReg.slmRun < (sReg.rx_path_config_one[SRPPS_CF_SLM_CNT] ? SRPPS_SLM_N5 : SRPPS_SLM_N3)) begin
               sNext.slmRun = sReg.slmRun + 3'h1;
            end
            if (sReg.slmRun + 3'h1 >= (sReg.rx_path_config_one[SRPPS_CF_SLM_CNT] ? SRPPS_SLM_N5 : SRPPS_SLM_N3)) begin
               sNext.slmSt = 1'b1;
            end
         end else begin
            sNext.slmRun = 3'h0;
            sNext.slmSt = 1'b0;
         end
         if (sReg.rx_path_config_one[SRPPS_CF_B3_BLOCK]) begin
            sNext.b3Count = sReg.b3Count + {15'h0, (b3BitErrors != 4'h0)};
         end else begin
            sNext.b3Count = sReg.b3Count + {12'h000, b3BitErrors};
         end
         if (sReg.rx_path_config_one[SRPPS_CF_REI_BLOCK]) begin
            sNext.reiCount = sReg.reiCount + {15'h0, (reiBitErrors != 4'h0)};
         end else begin
            sNext.reiCount = sReg.reiCount + {12'h000, reiBitErrors};
         end
      end
   end

   // all block state except the reset pipe and the RDI filter in one register
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         sReg <= '{bus: SRPPS_BUS_IDLE, rdata: 32'h0,
                   rx_path_config_one: SRPPS_CFG_RESET, default: '0};
      end else begin
         sReg <= sNext;
      end
   end

   // outputs
   assign avsWaitrequest = accept && (sReg.bus != SRPPS_BUS_ACK);
   assign avsReaddata    = sReg.rdata;
   assign path_rdi_status = rdiAcc;
   assign label_mismatch_status = sReg.slmSt ||
          (sReg.rx_path_config_one[SRPPS_CF_SLM_FORCE] && label_unstable_status);
   assign payloadColumn = !(sts1Mode && sReg.rx_path_config_one[SRPPS_CF_STUFF] &&
                            (speColumn == SRPPS_STUFF_COL_A || speColumn == SRPPS_STUFF_COL_B));
   assign rdiPayloadInsert = sReg.rx_path_config_one[SRPPS_CF_RDI_LCD] && cell_delineation_loss_status;
   assign irq = |(sReg.rx_pointer_event_latch & sReg.evtEnable);

   // assertions
   property p_ais_frame;
      @(posedge clk) disable iff (!rstSyncN)
      ptrValid |=> (sReg.rx_pointer_status[SRPPS_ST_AIS] == $past(ptrWord == SRPPS_ALL_ONES));
   endproperty
   a_ais_frame: assert property (p_ais_frame) else $error("ais status wrong");

   property p_ndf;
      @(posedge clk) disable iff (!rstSyncN)
      ptrValid |=> sReg.rx_pointer_status[SRPPS_ST_NDF] == ($past(ptrWord[15:12]) == SRPPS_CONCAT_NDF);
   endproperty
   a_ndf: assert property (p_ndf) else $error("ndf mirror wrong");

   property p_hold;
      @(posedge clk) disable iff (!rstSyncN)
      !ptrValid |=> $stable(sReg.rx_pointer_status);
   endproperty
   a_hold: assert property (p_hold) else $error("status changed without frame");

   property p_latch;
      @(posedge clk) disable iff (!rstSyncN)
      (ptrValid && statusNew[SRPPS_ST_LOP] != sReg.rx_pointer_status[SRPPS_ST_LOP])
         |=> sReg.rx_pointer_event_latch[SRPPS_ST_LOP];
   endproperty
   a_latch: assert property (p_latch) else $error("event not latched");

   property p_irq;
      @(posedge clk) disable iff (!rstSyncN)
      (ptrValid && !avsWrite && (((statusNew ^ sReg.rx_pointer_status) & sReg.evtEnable & 6'h27) != 6'h00))
         |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("enabled event did not raise irq");

   property p_slm_force;
      @(posedge clk) disable iff (!rstSyncN)
      (sReg.rx_path_config_one[SRPPS_CF_SLM_FORCE] && label_unstable_status) |-> label_mismatch_status;
   endproperty
   a_slm_force: assert property (p_slm_force) else $error("unstable did not force");

   property p_lcd;
      @(posedge clk) disable iff (!rstSyncN)
      !sReg.rx_path_config_one[SRPPS_CF_RDI_LCD] |-> !rdiPayloadInsert;
   endproperty
   a_lcd: assert property (p_lcd) else $error("rdi inserted while disabled");

   property p_stuff;
      @(posedge clk) disable iff (!rstSyncN)
      !sts1Mode |-> payloadColumn;
   endproperty
   a_stuff: assert property (p_stuff) else $error("column dropped outside sts1");

   property p_size;
      @(posedge clk) disable iff (!rstSyncN)
      (ptrValid && !ptrConcatCheck && sizeBad) |=> sReg.rx_pointer_status[SRPPS_ST_LOP];
   endproperty
   a_size: assert property (p_size) else $error("size mismatch missed");

   property p_concat;
      @(posedge clk) disable iff (!rstSyncN)
      (ptrValid && ptrConcatCheck && ptrWord[15:12] != SRPPS_CONCAT_NDF && ptrWord != SRPPS_ALL_ONES)
         |=> sReg.rx_pointer_status[SRPPS_ST_CONCAT];
   endproperty
   a_concat: assert property (p_concat) else $error("concat loss missed");

   property p_range;
      @(posedge clk) disable iff (!rstSyncN)
      (ptrValid && !ptrConcatCheck && ptrWord[9:0] > SRPPS_PTR_MAX && ptrWord != SRPPS_ALL_ONES)
         |=> sReg.rx_pointer_status[SRPPS_ST_LOP];
   endproperty
   a_range: assert property (p_range) else $error("invalid pointer missed");

   property p_status_ro;
      @(posedge clk) disable iff (!rstSyncN)
      (!ptrValid && avsWrite && !avsWaitrequest && avsAddress == SRPPS_OFF_PTR_STATUS)
         |=> $stable(sReg.rx_pointer_status);
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status word written");

   property p_slm_clear;
      @(posedge clk) disable iff (!rstSyncN)
      (pohValid && !labelMismatch) |=> !sReg.slmSt;
   endproperty
   a_slm_clear: assert property (p_slm_clear) else $error("label mismatch held without mismatch");

   property p_wait;
      @(posedge clk) disable iff (!rstSyncN)
      (avsRead && avsWaitrequest) |=> !avsWaitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("bus answer late");

   c_ais: cover property (@(posedge clk) disable iff (!rstSyncN) sReg.rx_pointer_status[SRPPS_ST_AIS]);
   c_irq: cover property (@(posedge clk) disable iff (!rstSyncN) irq);
   c_slm: cover property (@(posedge clk) disable iff (!rstSyncN) sReg.slmSt);
   c_rd:  cover property (@(posedge clk) disable iff (!rstSyncN) avsRead && !avsWaitrequest);
endmodule : srpps_top
`default_nettype wire

// *** test/srpps_frame_src.sv ***
/*
 * Frame stream model: per frame one pointer word and one path overhead set.
 * Assumes the bench calls send_frame from one process, clock running.
 */
`timescale 1ns/10ps
`default_nettype none
module srpps_frame_src (
   // clock
   input  wire logic        clk,
   // pointer side
   output var  logic        ptrValid,
   output var  logic [15:0] ptrWord,
   output var  logic        ptrConcatCheck,
   // path overhead side
   output var  logic        pohValid,
   output var  logic [7:0]  pohG1,
   output var  logic        labelMismatch,
   output var  logic        labelUnstable,
   output var  logic [3:0]  errCount
);
   // idle lines at time zero
   initial begin
      ptrValid = 1'b0;
      ptrWord = 16'h0000;
      ptrConcatCheck = 1'b0;
      pohValid = 1'b0;
      pohG1 = 8'h00;
      labelMismatch = 1'b0;
      labelUnstable = 1'b0;
      errCount = 4'h0;
   end

   // strobe one cycle; afterwards all data but labelUnstable turns over so stale values never look valid
   task automatic send_frame(input logic [15:0] w, input logic cc, input logic [7:0] g1,
                             input logic lm, input logic lu, input logic [3:0] e);
      @(posedge clk);
      ptrValid <= 1'b1;
      pohValid <= 1'b1;
      ptrWord <= w;
      ptrConcatCheck <= cc;
      pohG1 <= g1;
      labelMismatch <= lm;
      labelUnstable <= lu;
      errCount <= e;
      @(posedge clk);
      ptrValid <= 1'b0;
      pohValid <= 1'b0;
      ptrWord <= ~w;
      ptrConcatCheck <= ~cc;
      pohG1 <= ~g1;
      labelMismatch <= ~lm;
      errCount <= ~e;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : send_frame
endmodule : srpps_frame_src
`default_nettype wire

// *** test/srpps_top_bench.sv ***
/*
 * Self-checking bench for the receive pointer and path status block.
 * Assumes a 125 MHz clock and the one-wait-cycle Avalon-MM slave timing.
 */
`timescale 1ns/10ps
`default_nettype none
`define SRPPS_CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
   $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module srpps_top_bench;
   import srpps_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  avsAddress = 8'h00;
   logic        avsRead = 1'b0;
   logic        avsWrite = 1'b0;
   logic [31:0] avsWritedata = 32'h00000000;
   logic [31:0] avsReaddata;
   logic        avsWaitrequest;
   wire  logic  ptrValid, ptrConcatCheck, pohValid, labelMismatch, labelUnstable;
   wire  logic [15:0] ptrWord;
   wire  logic [7:0]  pohG1;
   wire  logic [3:0]  errCount;
   logic        sts1Mode = 1'b0;
   logic [6:0]  speColumn = 7'h00;
   logic        cellLoss = 1'b0;
   logic        payloadColumn, rdiPayloadInsert, labelStatus, irq;
   logic [2:0]  rdiStatus;
   logic [31:0] rdData;
   int          fail_count = 0;
   int          compares = 0;

   always #4 clk = ~clk;

   srpps_frame_src u_srpps_frame_src (.clk(clk), .ptrValid(ptrValid), .ptrWord(ptrWord),
      .ptrConcatCheck(ptrConcatCheck), .pohValid(pohValid), .pohG1(pohG1),
      .labelMismatch(labelMismatch), .labelUnstable(labelUnstable), .errCount(errCount));

   srpps_top u_srpps_top (.clk(clk), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
      .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
      .avsWaitrequest(avsWaitrequest), .ptrValid(ptrValid), .ptrWord(ptrWord),
      .ptrConcatCheck(ptrConcatCheck), .pohValid(pohValid), .pohG1(pohG1),
      .labelMismatch(labelMismatch), .label_unstable_status(labelUnstable),
      .b3BitErrors(errCount), .reiBitErrors(errCount), .sts1Mode(sts1Mode),
      .speColumn(speColumn), .cell_delineation_loss_status(cellLoss),
      .payloadColumn(payloadColumn), .rdiPayloadInsert(rdiPayloadInsert),
      .path_rdi_status(rdiStatus), .label_mismatch_status(labelStatus), .irq(irq));

   // verdict and end of run, shared with the watchdog
   task automatic print_verdict();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict

   // hold reset 20 cycles, first request on the 4th edge after release
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : do_reset

   // one bus cycle, request held until waitrequest is sampled low; the watchdog bounds the wait
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= ~wr;
      avsWritedata <= {16'h0000, d};
      do begin
         @(posedge clk);
      end while (avsWaitrequest !== 1'b0);
      rdData = avsReaddata;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
   endtask : bus

   task automatic frame(input logic [15:0] w, input logic cc, input logic [7:0] g1,
                        input logic lm, input logic lu);
      u_srpps_frame_src.send_frame(w, cc, g1, lm, lu, 4'h0);
   endtask : frame

   // pointer frame then masked compare of the status word
   task automatic ptr_case(input logic [15:0] w, input logic cc, input logic [5:0] m, input logic [5:0] e);
      frame(w, cc, 8'h00, 1'b0, 1'b0);
      bus(1'b0, SRPPS_OFF_PTR_STATUS, 16'h0000);
      `SRPPS_CHK(rdData[5:0] & m, e)
   endtask : ptr_case

   task automatic t_regs();
      bus(1'b0, SRPPS_OFF_PATH_CFG, 16'h0000);
      `SRPPS_CHK(rdData[15:0], SRPPS_CFG_RESET)
      bus(1'b1, SRPPS_OFF_PATH_CFG, 16'hA5C0);
      bus(1'b0, SRPPS_OFF_PATH_CFG, 16'h0000);
      `SRPPS_CHK(rdData[15:0], 16'hA5C0)
      bus(1'b0, 8'hF0, 16'h0000);
      `SRPPS_CHK(rdData, 32'h00000000)
      bus(1'b1, SRPPS_OFF_PATH_CFG, SRPPS_CFG_RESET);
   endtask : t_regs

   task automatic t_pointer();
      ptr_case(16'hFFFF, 1'b0, 6'h07, 6'h01);
      ptr_case(16'h6000, 1'b0, 6'h07, 6'h00);
      ptr_case(16'h63FF, 1'b0, 6'h07, 6'h04);
      ptr_case(16'h9000, 1'b0, 6'h07, 6'h02);
      ptr_case(16'h93FF, 1'b1, 6'h20, 6'h00);
      ptr_case(16'h9000, 1'b1, 6'h20, 6'h20);
      ptr_case(16'hFFFF, 1'b1, 6'h20, 6'h00);
      bus(1'b1, SRPPS_OFF_SIZE_CFG, 16'h0011);
      ptr_case(16'h6000, 1'b0, 6'h04, 6'h04);
      ptr_case(16'h6800, 1'b0, 6'h04, 6'h00);
      bus(1'b1, SRPPS_OFF_SIZE_CFG, 16'h0010);
      ptr_case(16'h6000, 1'b0, 6'h04, 6'h00);
      bus(1'b1, SRPPS_OFF_PTR_STATUS, 16'h003F);
      bus(1'b0, SRPPS_OFF_PTR_STATUS, 16'h0000);
      `SRPPS_CHK(rdData[5:0], 6'h00)
   endtask : t_pointer

   task automatic t_events();
      bus(1'b0, SRPPS_OFF_EVENT, 16'h0000);
      bus(1'b1, SRPPS_OFF_EVT_ENABLE, 16'h0001);
      frame(16'hFFFF, 1'b0, 8'h00, 1'b0, 1'b0);
      `SRPPS_CHK(irq, 1'b1)
      bus(1'b0, SRPPS_OFF_EVENT, 16'h0000);
      `SRPPS_CHK(rdData[0], 1'b1)
      bus(1'b0, SRPPS_OFF_EVENT, 16'h0000);
      `SRPPS_CHK(rdData[0], 1'b0)
      @(negedge clk);
      `SRPPS_CHK(irq, 1'b0)
      bus(1'b1, SRPPS_OFF_EVT_ENABLE, 16'h0000);
      frame(16'h6000, 1'b0, 8'h00, 1'b0, 1'b0);
      `SRPPS_CHK(irq, 1'b0)
      bus(1'b1, SRPPS_OFF_EVT_CLEAR, 16'h003F);
      bus(1'b0, SRPPS_OFF_EVENT, 16'h0000);
      `SRPPS_CHK(rdData[0], 1'b0)
   endtask : t_events

   // five equal bytes needed by default; non-enhanced ignores G1 bits 2:1
   task automatic t_rdi();
      for (int i = 0; i < 4; i++) frame(16'h6000, 1'b0, 8'h0A, 1'b0, 1'b0);
      `SRPPS_CHK(rdiStatus, 3'b000)
      frame(16'h6000, 1'b0, 8'h0A, 1'b0, 1'b0);
      `SRPPS_CHK(rdiStatus, 3'b101)
      bus(1'b1, SRPPS_OFF_PATH_CFG, 16'h0080);
      frame(16'h6000, 1'b0, 8'h06, 1'b0, 1'b0);
      frame(16'h6000, 1'b0, 8'h04, 1'b0, 1'b0);
      `SRPPS_CHK(rdiStatus[2], 1'b1)
      frame(16'h6000, 1'b0, 8'h02, 1'b0, 1'b0);
      `SRPPS_CHK(rdiStatus[2], 1'b0)
   endtask : t_rdi

   task automatic t_label();
      for (int i = 0; i < 3; i++) frame(16'h6000, 1'b0, 8'h00, 1'b0, 1'b1);
      `SRPPS_CHK(labelStatus, 1'b0)
      for (int i = 0; i < 2; i++) frame(16'h6000, 1'b0, 8'h00, 1'b1, 1'b0);
      `SRPPS_CHK(labelStatus, 1'b0)
      frame(16'h6000, 1'b0, 8'h00, 1'b1, 1'b0);
      `SRPPS_CHK(labelStatus, 1'b1)
      do_reset();
      bus(1'b1, SRPPS_OFF_PATH_CFG, 16'h7080);
      for (int i = 0; i < 4; i++) frame(16'h6000, 1'b0, 8'h00, 1'b1, 1'b0);
      `SRPPS_CHK(labelStatus, 1'b0)
      frame(16'h6000, 1'b0, 8'h00, 1'b1, 1'b0);
      `SRPPS_CHK(labelStatus, 1'b1)
      do_reset();
      bus(1'b1, SRPPS_OFF_PATH_CFG, 16'h6880);
      frame(16'h6000, 1'b0, 8'h00, 1'b0, 1'b1);
      `SRPPS_CHK(labelStatus, 1'b1)
      frame(16'h6000, 1'b0, 8'h00, 1'b0, 1'b0);
   endtask : t_label

   // a frame with five bit errors counts five, or one block; the two mode bits act apart
   task automatic t_count();
      logic [15:0] b, r;
      for (int m = 0; m < 3; m++) begin
         bus(1'b1, SRPPS_OFF_PATH_CFG, (m == 0) ? SRPPS_CFG_RESET : ((m == 1) ? 16'h6680 : 16'h6480));
         bus(1'b0, SRPPS_OFF_B3_COUNT, 16'h0000);
         b = rdData[15:0] + ((m == 0) ? 16'h0005 : 16'h0001);
         bus(1'b0, SRPPS_OFF_REI_COUNT, 16'h0000);
         r = rdData[15:0] + ((m == 1) ? 16'h0001 : 16'h0005);
         u_srpps_frame_src.send_frame(16'h6000, 1'b0, 8'h00, 1'b0, 1'b0, 4'h5);
         bus(1'b0, SRPPS_OFF_B3_COUNT, 16'h0000);
         `SRPPS_CHK(rdData[15:0], b)
         bus(1'b0, SRPPS_OFF_REI_COUNT, 16'h0000);
         `SRPPS_CHK(rdData[15:0], r)
      end
   endtask : t_count

   // drive column and mode at a rising edge, look half a cycle later
   task automatic col_case(input logic s, input logic [6:0] c, input logic e);
      @(posedge clk);
      sts1Mode <= s;
      speColumn <= c;
      @(negedge clk);
      `SRPPS_CHK(payloadColumn, e)
   endtask : col_case

   task automatic t_stuff_lcd();
      bus(1'b1, SRPPS_OFF_PATH_CFG, 16'h6180);
      col_case(1'b1, SRPPS_STUFF_COL_A, 1'b0);
      col_case(1'b1, SRPPS_STUFF_COL_B, 1'b0);
      col_case(1'b1, 7'h1F, 1'b1);
      col_case(1'b0, SRPPS_STUFF_COL_A, 1'b1);
      bus(1'b1, SRPPS_OFF_PATH_CFG, SRPPS_CFG_RESET);
      col_case(1'b1, SRPPS_STUFF_COL_B, 1'b1);
      @(posedge clk);
      cellLoss <= 1'b1;
      @(negedge clk);
      `SRPPS_CHK(rdiPayloadInsert, 1'b1)
      bus(1'b1, SRPPS_OFF_PATH_CFG, 16'h6000);
      @(negedge clk);
      `SRPPS_CHK(rdiPayloadInsert, 1'b0)
   endtask : t_stuff_lcd

   // watchdog well beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      print_verdict();
   end

   initial begin
      do_reset();
      t_regs();
      t_pointer();
      t_events();
      t_rdi();
      t_label();
      t_count();
      t_stuff_lcd();
      print_verdict();
   end
endmodule : srpps_top_bench
`undef SRPPS_CHK
`default_nettype wire
